// >>> verilog/nvc_host.sv
// Host controller that drives the bytewide clock RAM strobes and bus.
`timescale 1ns/1ps
module nvc_host (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // User request port
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [16:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic rsp_refused,
  // Device status
  input wire logic power_fail_flag_n,
  output logic power_fail,
  // Device pins
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  output logic [16:0] addr,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe_n
);
  nvc_pkg::nvc_state_t state;
  nvc_pkg::nvc_state_t next_state;
  logic [3:0] cnt;
  logic [7:0] dq_sync;
  logic pf_sync;
  logic is_write;
  logic cnt_done;

  // Clears unused timekeeping bits so host writes never set them.
  function automatic logic [7:0] clean_data(input logic [16:0] a, input logic [7:0] d);
    case (a)
      nvc_pkg::ADDR_CONTROL: clean_data = d & nvc_pkg::MASK_CONTROL;
      nvc_pkg::ADDR_SECONDS: clean_data = d & nvc_pkg::MASK_SECONDS;
      nvc_pkg::ADDR_MINUTES: clean_data = d & nvc_pkg::MASK_MINUTES;
      nvc_pkg::ADDR_HOUR: clean_data = d & nvc_pkg::MASK_HOUR;
      nvc_pkg::ADDR_DAY: clean_data = d & nvc_pkg::MASK_DAY;
      nvc_pkg::ADDR_DATE: clean_data = d & nvc_pkg::MASK_DATE;
      nvc_pkg::ADDR_MONTH: clean_data = d & nvc_pkg::MASK_MONTH;
      nvc_pkg::ADDR_YEAR: clean_data = d & nvc_pkg::MASK_YEAR;
      default: clean_data = d;
    endcase
  endfunction

  nvc_sync #(.WIDTH(9)) u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .async_in({power_fail_flag_n, dq_in}),
    .sync_out({pf_sync, dq_sync})
  );

  // The flag is inverted and synchronised; while it is low the host refuses requests and skips the access.
  assign power_fail = ~pf_sync;
  assign cnt_done = (cnt == nvc_pkg::CNT_W0);
  // Requests are refused while power fails, because the device ignores them.
  assign req_ready = (state == nvc_pkg::NVC_IDLE);

  always_comb begin
    next_state = state;
    case (state)
      nvc_pkg::NVC_IDLE: begin
        if (req_valid) begin
          next_state = pf_sync ? nvc_pkg::NVC_SETUP : nvc_pkg::NVC_RECOVER;
        end
      end
      nvc_pkg::NVC_SETUP: begin
        if (cnt_done) begin
          next_state = is_write ? nvc_pkg::NVC_STROBE : nvc_pkg::NVC_READ;
        end
      end
      nvc_pkg::NVC_READ: begin
        if (cnt_done) begin
          next_state = nvc_pkg::NVC_RECOVER;
        end
      end
      nvc_pkg::NVC_STROBE: begin
        if (cnt_done) begin
          next_state = nvc_pkg::NVC_HOLD;
        end
      end
      nvc_pkg::NVC_HOLD: begin
        if (cnt_done) begin
          next_state = nvc_pkg::NVC_RECOVER;
        end
      end
      nvc_pkg::NVC_RECOVER: begin
        if (cnt_done) begin
          next_state = nvc_pkg::NVC_IDLE;
        end
      end
      default: next_state = nvc_pkg::NVC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= nvc_pkg::NVC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Phase counter loaded on each state change.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 4'h0;
    end else if (next_state != state) begin
      case (next_state)
        nvc_pkg::NVC_SETUP: cnt <= 4'(nvc_pkg::T_AS_CYC - 1);
        nvc_pkg::NVC_READ: cnt <= 4'(nvc_pkg::T_RC_CYC - 1);
        nvc_pkg::NVC_STROBE: cnt <= 4'(nvc_pkg::T_WEW_CYC - 1);
        nvc_pkg::NVC_HOLD: cnt <= 4'(nvc_pkg::T_DH_CYC - 1);
        nvc_pkg::NVC_RECOVER: cnt <= 4'(nvc_pkg::T_WR_CYC + nvc_pkg::T_OFF_CYC - 1);
        default: cnt <= 4'h0;
      endcase
    end else if (!cnt_done) begin
      cnt <= cnt - 4'h1;
    end
  end

  // Address and write data are taken once and held through the cycle.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      addr <= 17'h00000;
      dq_out <= 8'h00;
      is_write <= 1'b0;
    end else if (state == nvc_pkg::NVC_IDLE && req_valid) begin
      addr <= req_addr;
      dq_out <= clean_data(req_addr, req_wdata);
      is_write <= req_write;
    end
  end

  // Strobes come from flops so the pins are glitch free.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
      dq_oe_n <= 1'b1;
    end else begin
      ce_n <= !(next_state inside {nvc_pkg::NVC_SETUP, nvc_pkg::NVC_READ,
        nvc_pkg::NVC_STROBE});
      // Write starts on strobe fall after select is already low.
      we_n <= !(next_state == nvc_pkg::NVC_STROBE);
      // Gate stays high in writes so the bus never has two drivers.
      oe_n <= !(next_state == nvc_pkg::NVC_READ);
      // Data is driven from strobe through hold, past the end of write.
      dq_oe_n <= !(is_write && next_state inside {nvc_pkg::NVC_STROBE,
        nvc_pkg::NVC_HOLD});
    end
  end

  // Read data is sampled at the end of the access, after access time.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
      rsp_refused <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      rsp_refused <= 1'b0;
      if (state == nvc_pkg::NVC_IDLE && req_valid && !pf_sync) begin
        rsp_valid <= 1'b1;
        rsp_refused <= 1'b1;
      end else if (state == nvc_pkg::NVC_READ && cnt_done) begin
        rsp_valid <= 1'b1;
        rsp_rdata <= dq_sync;
      end else if (state == nvc_pkg::NVC_HOLD && cnt_done) begin
        rsp_valid <= 1'b1;
      end
    end
  end

  chk_write_gate_high: assert property (@(posedge ref_clk) disable iff (!rstn)
    !we_n |-> oe_n) else $error("Output gate low during write.");
  chk_write_select_low: assert property (@(posedge ref_clk) disable iff (!rstn)
    !we_n |-> !ce_n) else $error("Write strobe without select.");
  chk_data_driven: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(we_n) |-> !dq_oe_n) else $error("Data released at write end.");
  chk_addr_stable: assert property (@(posedge ref_clk) disable iff (!rstn)
    !ce_n && !$past(ce_n) |-> $stable(addr)) else $error("Address moved.");
  chk_recovery_gap: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(ce_n) |-> ce_n [*3]) else $error("Recovery too short.");
  chk_strobe_width: assert property (@(posedge ref_clk) disable iff (!rstn)
    $fell(we_n) |-> !we_n [*4]) else $error("Write strobe too short.");
  chk_unused_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
    !we_n && addr == nvc_pkg::ADDR_CONTROL |-> dq_out[5:0] == 6'h00)
    else $error("Unused bits written.");
  chk_pf_block: assert property (@(posedge ref_clk) disable iff (!rstn)
    req_valid && req_ready && !pf_sync |=> rsp_refused && ce_n)
    else $error("Access during power fail.");
  cov_read: cover property (@(posedge ref_clk) disable iff (!rstn)
    $fell(oe_n) ##[1:10] rsp_valid && !rsp_refused);
  cov_write: cover property (@(posedge ref_clk) disable iff (!rstn) $rose(we_n));
  cov_refused: cover property (@(posedge ref_clk) disable iff (!rstn) rsp_refused);
endmodule

// >>> verilog/nvc_pkg.sv
// Package with the constants of the nonvolatile clock RAM host controller.
package nvc_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam logic [16:0] ADDR_CONTROL = 17'h1FFF8;
  localparam logic [16:0] ADDR_SECONDS = 17'h1FFF9;
  localparam logic [16:0] ADDR_MINUTES = 17'h1FFFA;
  localparam logic [16:0] ADDR_HOUR = 17'h1FFFB;
  localparam logic [16:0] ADDR_DAY = 17'h1FFFC;
  localparam logic [16:0] ADDR_DATE = 17'h1FFFD;
  localparam logic [16:0] ADDR_MONTH = 17'h1FFFE;
  localparam logic [16:0] ADDR_YEAR = 17'h1FFFF;
  localparam int CTRL_WRITE_BIT = 7;
  localparam int CTRL_READ_BIT = 6;
  localparam int SEC_HALT_BIT = 7;
  localparam int DAY_FREQ_TEST_BIT = 6;
  // Masks of the bits in use; unused bits are forced to zero on writes.
  localparam logic [7:0] MASK_CONTROL = 8'hC0;
  localparam logic [7:0] MASK_SECONDS = 8'hFF;
  localparam logic [7:0] MASK_MINUTES = 8'h7F;
  localparam logic [7:0] MASK_HOUR = 8'h3F;
  localparam logic [7:0] MASK_DAY = 8'h47;
  localparam logic [7:0] MASK_DATE = 8'h3F;
  localparam logic [7:0] MASK_MONTH = 8'h1F;
  localparam logic [7:0] MASK_YEAR = 8'hFF;
  // Timing in ns and the derived cycle counts at 40 MHz.
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_RC_NS = 120;
  localparam int T_WC_NS = 120;
  localparam int T_AS_NS = 0;
  localparam int T_WEW_NS = 75;
  localparam int T_DS_NS = 85;
  localparam int T_DH_NS = 25;
  localparam int T_WR_NS = 10;
  localparam int T_OEZ_NS = 40;
  localparam int T_WEZ_NS = 40;
  localparam int T_AS_CYC = (T_AS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
    (T_AS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RC_CYC = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_WEW_CYC = (T_DS_NS > T_WEW_NS ? T_DS_NS : T_WEW_NS) / CLK_PERIOD_NS + 1;
  localparam int T_DH_CYC = (T_DH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_WR_CYC = (T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_OFF_CYC = ((T_OEZ_NS > T_WEZ_NS ? T_OEZ_NS : T_WEZ_NS)
    + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] CNT_W0 = 4'h0;
  typedef enum logic [5:0] {
    NVC_IDLE = 6'h01,
    NVC_SETUP = 6'h02,
    NVC_READ = 6'h04,
    NVC_STROBE = 6'h08,
    NVC_HOLD = 6'h10,
    NVC_RECOVER = 6'h20
  } nvc_state_t;
endpackage

// >>> verilog/nvc_sync.sv
// Two-flop synchroniser for levels entering from the device pins.
`timescale 1ns/1ps
module nvc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Level in and out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// >>> dv/nvc_dev_model.sv
// Pin-level model of the bytewide clock RAM facing the host controller.
`timescale 1ns/1ps
module nvc_dev_model (
  // Strobes and bus from the host
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [16:0] addr,
  input wire logic [7:0] dq_out,
  input wire logic dq_oe_n,
  // Supply condition set by the bench
  input wire logic supply_low,
  // Oscillator tick standing for both the seconds rate and the test rate
  input wire logic osc_tick,
  // Device outputs
  output logic [7:0] dq_in,
  output logic power_fail_flag_n
);
  // Only the low address byte is decoded, so the model stays small.
  logic [7:0] mem [0:255];
  logic [7:0] last_dq = 8'h00;
  logic sel_n;
  logic drive;
  logic wr_on;
  // Only the seconds counter runs; the other clock registers stay plain memory.
  logic [6:0] run_sec = 7'h00;
  logic osc_prev = 1'b0;
  assign sel_n = ce_n | supply_low;
  assign power_fail_flag_n = !supply_low;
  assign drive = !sel_n && !oe_n && we_n;
  assign wr_on = !sel_n && !we_n;
  always @* begin
    if (!dq_oe_n) begin
      dq_in = dq_out;
    end else if (drive) begin
      dq_in = mem[addr[7:0]];
    end else begin
      // A released bus has no pull, so it must not keep its last value.
      dq_in = ~last_dq;
    end
  end
  always @(dq_in) begin
    if (!dq_oe_n || drive) begin
      last_dq = dq_in;
    end
  end
  // Writes and ticks share one process so the memory has a single writer.
  always @(negedge wr_on or posedge osc_tick) begin
    if (osc_tick && !osc_prev) begin
      if (mem[8'hF9][7]) begin
        run_sec = run_sec;
      end else if (mem[8'hFC][6]) begin
        mem[8'hF9][0] = ~mem[8'hF9][0];
      end else begin
        run_sec = run_sec + 7'h01;
        if (mem[8'hF8][7:6] == 2'b00) begin
          mem[8'hF9][6:0] = run_sec;
        end
      end
    end else begin
      if (addr[7:0] == 8'hF8 && !dq_in[7] && mem[8'hF8][7]) begin
        run_sec = mem[8'hF9][6:0];
      end
      mem[addr[7:0]] = dq_in;
    end
    osc_prev = osc_tick;
  end
endmodule

// >>> dv/tb_nvc_host.sv
// Self-checking bench for the clock RAM host controller.
`timescale 1ns/1ps
module tb_nvc_host;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [16:0] req_addr = 17'h00000;
  logic [7:0] req_wdata = 8'h00;
  logic supply_low = 1'b0;
  logic osc_tick = 1'b0;
  logic req_ready, rsp_valid, rsp_refused, power_fail, ce_n, we_n, oe_n, dq_oe_n;
  logic power_fail_flag_n;
  logic [7:0] rsp_rdata, dq_in, dq_out;
  logic [16:0] addr;
  logic [7:0] got_rd;
  logic got_ref;
  int ce_falls = 0;
  int ce_before = 0;
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;
  // Each row: address, value written, value expected back.
  logic [32:0] rows [10] = '{
    {17'h00005, 8'hA5, 8'hA5}, {17'h00000, 8'hFF, 8'hFF},
    {nvc_pkg::ADDR_CONTROL, 8'hFF, 8'hC0}, {nvc_pkg::ADDR_SECONDS, 8'h80, 8'h80},
    {nvc_pkg::ADDR_MINUTES, 8'hFF, 8'h7F}, {nvc_pkg::ADDR_HOUR, 8'hFF, 8'h3F},
    {nvc_pkg::ADDR_DAY, 8'hFF, 8'h47}, {nvc_pkg::ADDR_DATE, 8'hFF, 8'h3F},
    {nvc_pkg::ADDR_MONTH, 8'hFF, 8'h1F}, {nvc_pkg::ADDR_YEAR, 8'h99, 8'h99}};
  always #12.5 ref_clk = ~ref_clk;
  nvc_host i_dut (.ref_clk(ref_clk), .rstn(rstn), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_refused(rsp_refused), .power_fail_flag_n(power_fail_flag_n),
    .power_fail(power_fail), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n));
  nvc_dev_model i_dev (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n), .supply_low(supply_low), .osc_tick(osc_tick),
    .dq_in(dq_in), .power_fail_flag_n(power_fail_flag_n));
  always @(negedge ce_n) ce_falls++;
  task automatic wrap_up();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic access(input logic w, input logic [16:0] a, input logic [7:0] d);
    int n;
    n = 0;
    // Ready is looked at mid-cycle, where it has settled after the edge.
    @(negedge ref_clk);
    while (req_ready !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 30);
    check("rsp_valid", {7'h00, rsp_valid}, 8'h01);
    check("busy at answer", {7'h00, req_ready}, 8'h00);
    got_rd = rsp_rdata;
    got_ref = rsp_refused;
  endtask
  task automatic tick_read();
    @(posedge ref_clk);
    osc_tick <= 1'b1;
    @(posedge ref_clk);
    osc_tick <= 1'b0;
    access(1'b0, nvc_pkg::ADDR_SECONDS, 8'h00);
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    check("idle strobes", {4'h0, ce_n, we_n, oe_n, dq_oe_n}, 8'h0F);
    check("power_fail in reset", {7'h00, power_fail}, 8'h01);
    rstn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < 10; i++) begin
      access(1'b1, rows[i][32:16], rows[i][15:8]);
    end
    for (int i = 0; i < 10; i++) begin
      access(1'b0, rows[i][32:16], 8'h00);
      check("read data", got_rd, rows[i][7:0]);
      check("read refused", {7'h00, got_ref}, 8'h00);
    end
    // Clock registers start frozen by the control row; one tick per step.
    access(1'b1, nvc_pkg::ADDR_DAY, 8'h00);
    access(1'b1, nvc_pkg::ADDR_SECONDS, 8'h05);
    tick_read();
    check("frozen seconds", got_rd, 8'h05);
    access(1'b1, nvc_pkg::ADDR_CONTROL, 8'h00);
    tick_read();
    check("loaded seconds", got_rd, 8'h06);
    access(1'b1, nvc_pkg::ADDR_SECONDS, 8'h80);
    tick_read();
    check("halted seconds", got_rd, 8'h80);
    access(1'b1, nvc_pkg::ADDR_SECONDS, 8'h00);
    access(1'b1, nvc_pkg::ADDR_DAY, 8'h40);
    tick_read();
    check("test toggle", got_rd, 8'h01);
    // Writes during a supply dip must be refused without pulling select low.
    supply_low <= 1'b1;
    repeat (4) @(negedge ref_clk);
    check("power_fail set", {7'h00, power_fail}, 8'h01);
    ce_before = ce_falls;
    access(1'b1, 17'h00005, 8'h5A);
    check("refused", {7'h00, got_ref}, 8'h01);
    check("select during fail", 8'(ce_falls - ce_before), 8'h00);
    supply_low <= 1'b0;
    repeat (4) @(negedge ref_clk);
    check("power_fail clear", {7'h00, power_fail}, 8'h00);
    access(1'b0, 17'h00005, 8'h00);
    check("kept data", got_rd, 8'hA5);
    wrap_up();
  end
endmodule
